//--- design/mm_stream_adapters.v
`timescale 1ns/1ns
`default_nettype none
`include "stream_adapter_defs.vh"
// Contract
// - Write side shows buffered sample one cycle after core ready.
// - Write side delivers samples oldest first, in arrival order.
// - Write valid high exactly when output holds a newly popped sample.
// - No bus read while stalled; core samples pile up in buffer.
// - Read side drops ready when its buffer is full.
// - Read side raises ready only while it can take a sample.
// - Bus capture valid high exactly when a real word is read.
// - Sample width and buffer depth come from parameters.
module mm_stream_adapters #(
  parameter DATA_W = `SA_DATA_W,
  parameter DEPTH = `SA_DEPTH,
  parameter ADDR_W = `SA_ADDR_W
) (
  input wire i_mclk,
  input wire i_srst,
  // Write adapter: bus side
  input wire i_bus_write,
  input wire [DATA_W-1:0] i_bus_wdata,
  output wire o_bus_wready,
  // Write adapter: stream side
  input wire i_core_ready,
  output wire [DATA_W-1:0] o_stream_out_word,
  output wire o_stream_word_valid,
  // Read adapter: stream side
  input wire [DATA_W-1:0] i_core_word,
  input wire i_core_valid,
  output wire o_core_ready,
  // Read adapter: bus side
  input wire i_bus_read,
  output wire [DATA_W-1:0] o_bus_capture_word,
  output wire o_bus_capture_valid
);
  wire [DATA_W-1:0] wq_head;
  wire wq_full;
  wire wq_empty;
  wire wq_pop;
  wire [DATA_W-1:0] rq_head;
  wire rq_full;
  wire rq_empty;
  wire rq_push;
  wire rq_pop;
  reg [DATA_W-1:0] out_word_r;
  reg out_valid_r;
  reg [DATA_W-1:0] cap_word_r;
  reg cap_valid_r;

  // Write-side storage and its pointers
  reg [DATA_W-1:0] wmem_r [0:DEPTH-1];
  reg [ADDR_W-1:0] wwr_ptr_r;
  reg [ADDR_W-1:0] wrd_ptr_r;
  reg [ADDR_W:0] wcount_r;
  wire wq_push;
  wire wq_inc;
  wire wq_dec;

  // Advance a write-side pointer with wrap at the depth
  function [ADDR_W-1:0] wptr_inc;
    input [ADDR_W-1:0] p;
    begin
      if (p == DEPTH[ADDR_W-1:0] - {{(ADDR_W-1){1'b0}}, 1'b1}) begin
        wptr_inc = {ADDR_W{1'b0}};
      end else begin
        wptr_inc = p + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Occupancy flags; full refuses a write even if a pop falls alongside
  assign wq_full = (wcount_r == DEPTH[ADDR_W:0]);
  assign wq_empty = (wcount_r == {(ADDR_W+1){1'b0}});
  assign wq_push = i_bus_write && !wq_full;
  assign wq_head = wmem_r[wrd_ptr_r]; // Oldest unsent sample

  // Bus write back-pressure
  assign o_bus_wready = !wq_full;
  // Pop head when core is ready and a sample waits
  assign wq_pop = i_core_ready && !wq_empty;
  // Count moves only when exactly one side acts
  assign wq_inc = wq_push && !wq_pop;
  assign wq_dec = wq_pop && !wq_push;

  // Storage write, in arrival order
  always @(posedge i_mclk) begin
    if (wq_push) begin
      wmem_r[wwr_ptr_r] <= i_bus_wdata;
    end
  end

  // Write pointer
  always @(posedge i_mclk) begin
    if (i_srst) begin
      wwr_ptr_r <= {ADDR_W{1'b0}};
    end else if (wq_push) begin
      wwr_ptr_r <= wptr_inc(wwr_ptr_r);
    end
  end

  // Read pointer, moves only on a real pop
  always @(posedge i_mclk) begin
    if (i_srst) begin
      wrd_ptr_r <= {ADDR_W{1'b0}};
    end else if (wq_pop) begin
      wrd_ptr_r <= wptr_inc(wrd_ptr_r);
    end
  end

  // Occupancy count
  always @(posedge i_mclk) begin
    if (i_srst) begin
      wcount_r <= {(ADDR_W+1){1'b0}};
    end else if (wq_inc) begin
      wcount_r <= wcount_r + {{ADDR_W{1'b0}}, 1'b1};
    end else if (wq_dec) begin
      wcount_r <= wcount_r - {{ADDR_W{1'b0}}, 1'b1};
    end
  end

  // Output word: next sample the cycle after ready, else holds last
  always @(posedge i_mclk) begin
    if (i_srst) begin
      out_word_r <= `SA_WORD_RST;
    end else if (wq_pop) begin
      out_word_r <= wq_head;
    end
  end

  // Output valid: one cycle per sample, low on underflow
  always @(posedge i_mclk) begin
    if (i_srst) begin
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= wq_pop;
    end
  end

  assign o_stream_out_word = out_word_r;
  assign o_stream_word_valid = out_valid_r;

  // Read adapter queue, core samples wait for bus reads
  sample_queue #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) u_read_queue (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_push(rq_push),
    .i_push_word(i_core_word),
    .i_pop(rq_pop),
    .o_head_word(rq_head),
    .o_full(rq_full),
    .o_empty(rq_empty)
  );

  // Ready only while space remains
  assign o_core_ready = !rq_full;
  assign rq_push = i_core_valid && o_core_ready;
  assign rq_pop = i_bus_read && !rq_empty;

  // Bus capture register, valid only for real words
  always @(posedge i_mclk) begin
    if (i_srst) begin
      cap_word_r <= `SA_WORD_RST;
      cap_valid_r <= 1'b0;
    end else begin
      cap_valid_r <= rq_pop;
      if (rq_pop) begin
        cap_word_r <= rq_head;
      end
    end
  end

  assign o_bus_capture_word = cap_word_r;
  assign o_bus_capture_valid = cap_valid_r;
endmodule // mm_stream_adapters
`default_nettype wire

//--- design/sample_queue.v
`timescale 1ns/1ns
`default_nettype none
`include "stream_adapter_defs.vh"
// Circular sample buffer with honest full and empty
module sample_queue #(
  parameter DATA_W = `SA_DATA_W,
  parameter DEPTH = `SA_DEPTH,
  parameter ADDR_W = `SA_ADDR_W
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_push,
  input wire [DATA_W-1:0] i_push_word,
  input wire i_pop,
  output wire [DATA_W-1:0] o_head_word,
  output wire o_full,
  output wire o_empty
);
  reg [DATA_W-1:0] mem_r [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_r;
  reg [ADDR_W-1:0] rd_ptr_r;
  reg [ADDR_W:0] count_r;
  wire do_push;
  wire do_pop;

  // Advance a pointer with wrap at the depth
  function [ADDR_W-1:0] ptr_inc;
    input [ADDR_W-1:0] p;
    begin
      if (p == DEPTH[ADDR_W-1:0] - {{(ADDR_W-1){1'b0}}, 1'b1}) begin
        ptr_inc = {ADDR_W{1'b0}};
      end else begin
        ptr_inc = p + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  assign o_full = (count_r == DEPTH[ADDR_W:0]);
  assign o_empty = (count_r == {(ADDR_W+1){1'b0}});
  assign do_push = i_push && !o_full;
  assign do_pop = i_pop && !o_empty;
  assign o_head_word = mem_r[rd_ptr_r];

  // Storage write
  always @(posedge i_mclk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= i_push_word;
    end
  end

  // Pointers and occupancy
  always @(posedge i_mclk) begin
    if (i_srst) begin
      wr_ptr_r <= {ADDR_W{1'b0}};
      rd_ptr_r <= {ADDR_W{1'b0}};
      count_r <= {(ADDR_W+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (do_pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + {{ADDR_W{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count_r <= count_r - {{ADDR_W{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sample_queue
`default_nettype wire

//--- design/stream_adapter_defs.vh
`ifndef STREAM_ADAPTER_DEFS_VH
`define STREAM_ADAPTER_DEFS_VH
// Default sample width and buffer depth
`define SA_DATA_W 8
`define SA_DEPTH 16
`define SA_ADDR_W 4
// Reset values
`define SA_PTR_RST 4'h0
`define SA_CNT_RST 5'h00
`define SA_WORD_RST 8'h00
`endif

//--- tb/bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// Bus master: counting writes and reads
module bus_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_hold,
  input wire logic i_wen,
  input wire logic i_ren,
  input wire logic i_rdy,
  output logic o_wr,
  output logic [7:0] o_wd,
  output logic o_rd
);
  // Held while stalled, one per clock after
  assign o_wr = i_wen & ~i_hold;
  assign o_rd = i_ren & ~i_hold;
  // Word advances per accepted write
  always @(posedge i_mclk) begin
    if (i_srst)
      o_wd <= 8'h00;
    else if (o_wr & i_rdy)
      o_wd <= o_wd + 8'h01;
  end
endmodule // bus_model
`default_nettype wire

//--- tb/stream_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Port checker
module stream_monitor (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_bus_write,
  input wire logic o_bus_wready,
  input wire logic i_core_ready,
  input wire logic o_stream_word_valid,
  input wire logic i_core_valid,
  input wire logic o_core_ready,
  input wire logic i_bus_read,
  input wire logic [7:0] o_bus_capture_word,
  input wire logic o_bus_capture_valid
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Write side
  property p_pop; i_core_ready && !o_bus_wready |=> o_stream_word_valid; endproperty
  a_pop: assert property (p_pop) else $error("no pop");
  property p_ov; o_stream_word_valid |-> $past(i_core_ready); endproperty
  a_ov: assert property (p_ov) else $error("bad valid");
  property p_wr; o_bus_wready && !i_bus_write |=> o_bus_wready; endproperty
  a_wr: assert property (p_wr) else $error("bad wready");
  // Read side
  property p_full; !o_core_ready && !i_bus_read |=> !o_core_ready; endproperty
  a_full: assert property (p_full) else $error("full lost");
  property p_rdy; o_core_ready && !i_core_valid |=> o_core_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready lost");
  property p_rd; i_bus_read && !o_core_ready |=> o_bus_capture_valid; endproperty
  a_rd: assert property (p_rd) else $error("no read");
  property p_cv; o_bus_capture_valid |-> $past(i_bus_read); endproperty
  a_cv: assert property (p_cv) else $error("stray read");
  property p_cw; !o_bus_capture_valid && !$past(i_srst) |-> $stable(o_bus_capture_word); endproperty
  a_cw: assert property (p_cw) else $error("word moved");
  // Main scenarios
  cover property (o_stream_word_valid);
  cover property (!o_core_ready);
  cover property (!o_bus_wready);
endmodule // stream_monitor
bind mm_stream_adapters stream_monitor stream_monitor_inst (
  .i_mclk(i_mclk),
  .i_srst(i_srst),
  .i_bus_write(i_bus_write),
  .o_bus_wready(o_bus_wready),
  .i_core_ready(i_core_ready),
  .o_stream_word_valid(o_stream_word_valid),
  .i_core_valid(i_core_valid),
  .o_core_ready(o_core_ready),
  .i_bus_read(i_bus_read),
  .o_bus_capture_word(o_bus_capture_word),
  .o_bus_capture_valid(o_bus_capture_valid)
);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0, i_srst = 1'b1, i_core_ready = 1'b0, i_core_valid = 1'b0;
  logic hold = 1'b0, wen = 1'b0, ren = 1'b0;
  logic [7:0] i_core_word = 8'h00;
  wire i_bus_write, i_bus_read, o_bus_wready, o_core_ready;
  wire o_stream_word_valid, o_bus_capture_valid;
  wire [7:0] i_bus_wdata, o_stream_out_word, o_bus_capture_word;
  int bad_count = 0;
  int total_checks = 0;
  // Core word in, capture word out
  logic [15:0] rows [3] = '{16'h3C3C, 16'h0000, 16'hFFFF};
  mm_stream_adapters mm_stream_adapters_inst (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_bus_write(i_bus_write),
    .i_bus_wdata(i_bus_wdata),
    .o_bus_wready(o_bus_wready),
    .i_core_ready(i_core_ready),
    .o_stream_out_word(o_stream_out_word),
    .o_stream_word_valid(o_stream_word_valid),
    .i_core_word(i_core_word),
    .i_core_valid(i_core_valid),
    .o_core_ready(o_core_ready),
    .i_bus_read(i_bus_read),
    .o_bus_capture_word(o_bus_capture_word),
    .o_bus_capture_valid(o_bus_capture_valid)
  );
  bus_model bus_model_inst (.i_mclk, .i_srst, .i_hold(hold), .i_wen(wen), .i_ren(ren),
    .i_rdy(o_bus_wready), .o_wr(i_bus_write), .o_wd(i_bus_wdata), .o_rd(i_bus_read));
  always #5 i_mclk = ~i_mclk;
  task chk(input logic [8:0] seen, input logic [8:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, seen, want);
    end
  endtask
  task end_sim;
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Drain a queue: 16 words oldest first, then none
  task drain(input logic cap);
    logic [8:0] got;
    for (int k = 0; k < 17; k++) begin
      @(posedge i_mclk);
      #1;
      got = cap ? {o_bus_capture_valid, o_bus_capture_word}
                : {o_stream_word_valid, o_stream_out_word};
      chk(got, k < 16 ? {1'b1, k[7:0]} : 9'h00F);
    end
  endtask
  // Hang guard
  initial begin
    #20000;
    bad_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    chk({o_stream_word_valid, o_core_ready, o_bus_wready}, 9'h003);
    foreach (rows[i]) begin
      i_core_word = rows[i][15:8];
      i_core_valid = 1'b1;
      @(posedge i_mclk);
      #1 i_core_valid = 1'b0;
      ren = 1'b1;
      @(posedge i_mclk);
      #1 ren = 1'b0;
      chk({o_bus_capture_valid, o_bus_capture_word}, {1'b1, rows[i][7:0]});
    end
    hold = 1'b1;
    ren = 1'b1;
    i_core_valid = 1'b1;
    for (int k = 0; k < 17; k++) begin
      i_core_word = k[7:0];
      @(posedge i_mclk);
      #1;
    end
    chk(o_core_ready, 9'h000);
    i_core_valid = 1'b0;
    hold = 1'b0;
    drain(1'b1);
    ren = 1'b0;
    wen = 1'b1;
    repeat (18) @(posedge i_mclk);
    #1 wen = 1'b0;
    chk(o_bus_wready, 9'h000);
    i_core_ready = 1'b1;
    drain(1'b0);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
